//--- rtl/enu_top.sv
// Event notification unit: APB registers, timestamps, packet queueing
// How it works
// - Accepted frame trigger raises event code 0x8020.
// - Rejected frame trigger raises event code 0x8021.
// - Start of trigger wait raises event code 0x8022.
// - Frame transfer begin raises event code 0x8030.
// - Frame transfer complete raises event code 0x8031.
// - Exposure begin raises event code 0x8040.
// - Exposure finish raises event code 0x8041.
// - Aux timer zero begin raises event code 0x9000.
// - Aux timer zero finish raises event code 0x9100.
// - Host selector picks one of nine events; resets to trigger accepted.
// - Notification setting is off after reset; off means no packets.
// - Each event type keeps a readable time of its latest occurrence.
// - Enabled events go to the host as packets with code and time.
`timescale 1ns/1ns
module enu_top
  import enu_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pipeline milestones
  input wire logic trigger_accepted_event,
  input wire logic trigger_rejected_event,
  input wire logic trigger_wait_event,
  input wire logic transfer_begin_event,
  input wire logic transfer_complete_event,
  input wire logic exposure_begin_event,
  input wire logic exposure_finish_event,
  input wire logic aux_timer_zero_begin_event,
  input wire logic aux_timer_zero_finish_event,
  // Event packet link
  output logic pkt_valid,
  output logic [15:0] pkt_code,
  output logic [31:0] pkt_time,
  input wire logic pkt_ready,
  // Interrupt
  output logic irq
);
  enu_evt_if evt ();
  logic [8:0] milestone;

  assign milestone = {aux_timer_zero_finish_event, aux_timer_zero_begin_event,
                      exposure_finish_event, exposure_begin_event,
                      transfer_complete_event, transfer_begin_event,
                      trigger_wait_event, trigger_rejected_event,
                      trigger_accepted_event};

  enu_detect u_detect (
    .pclk(pclk),
    .presetn(presetn),
    .milestone(milestone),
    .evt(evt)
  );

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  logic [3:0] event_type_chooser;
  logic [8:0] notify_on_off;
  logic [31:0] evt_time [ENU_NUM_EVT];
  logic [8:0] pend;
  logic [8:0] irq_stat;
  logic [8:0] irq_en;
  logic [3:0] next_chooser;
  logic [8:0] next_notify;
  logic [31:0] next_evt_time [ENU_NUM_EVT];
  logic [8:0] next_pend;
  logic [8:0] next_irq_stat;
  logic [8:0] next_irq_en;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic next_irq;
  logic wr_acc;
  logic rd_acc;
  logic [3:0] time_idx;
  logic [5:0] time_off;
  logic send_req;
  logic [3:0] send_idx;
  logic pkt_busy;

  assign wr_acc = psel && penable && pwrite && !pready;
  assign rd_acc = psel && penable && !pwrite && !pready;
  assign time_off = paddr[7:2] - ENU_OFF_TIME0[7:2];
  // Range checked on all six bits so high offsets cannot fold onto slot zero
  assign time_idx = time_off[3:0];
  assign send_idx = enu_first(pend);
  assign send_req = (pend != 9'h000);

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    next_chooser = event_type_chooser;
    next_notify = notify_on_off;
    next_irq_en = irq_en;
    next_evt_time = evt_time;
    next_pend = pend;
    next_irq_stat = irq_stat;
    next_prdata = 32'h0000_0000;
    next_pready = psel && penable && !pready;
    next_pslverr = 1'b0;
    // Clear first so a same-cycle event sets the bit again
    if (wr_acc && paddr == ENU_OFF_IRQ_CLR) begin
      next_irq_stat = irq_stat & ~pwdata[8:0];
    end
    if (send_req && !pkt_busy) begin
      next_pend[send_idx] = 1'b0;
    end
    for (int i = 0; i < ENU_NUM_EVT; i++) begin
      if (evt.hit[i]) begin
        next_evt_time[i] = evt.now;
        next_irq_stat[i] = 1'b1;
        if (notify_on_off[i]) begin
          next_pend[i] = 1'b1;
        end
      end
    end
    if (wr_acc) begin
      unique case (paddr)
        ENU_OFF_CHOOSER: begin
          if (pwdata[3:0] < 4'(ENU_NUM_EVT)) begin
            next_chooser = pwdata[3:0];
          end else begin
            next_pslverr = 1'b1;
          end
        end
        ENU_OFF_NOTIFY: next_notify[event_type_chooser] = pwdata[0];
        ENU_OFF_IRQ_EN: next_irq_en = pwdata[8:0];
        ENU_OFF_IRQ_CLR: ;
        default: next_pslverr = 1'b1;
      endcase
    end
    if (rd_acc) begin
      if (paddr == ENU_OFF_CHOOSER) begin
        next_prdata = {28'h0000000, event_type_chooser};
      end else if (paddr == ENU_OFF_NOTIFY) begin
        next_prdata = {31'h0, notify_on_off[event_type_chooser]};
      end else if (paddr == ENU_OFF_SEL_TIME) begin
        next_prdata = evt_time[event_type_chooser];
      end else if (paddr == ENU_OFF_IRQ_STAT) begin
        next_prdata = {23'h0, irq_stat};
      end else if (paddr == ENU_OFF_IRQ_EN) begin
        next_prdata = {23'h0, irq_en};
      end else if (paddr == ENU_OFF_NOW) begin
        next_prdata = evt.now;
      end else if (paddr[1:0] == 2'b00 && paddr >= ENU_OFF_TIME0
                   && time_off < 6'(ENU_NUM_EVT)) begin
        next_prdata = evt_time[time_idx];
      end else begin
        next_pslverr = 1'b1;
      end
    end
    next_irq = |(next_irq_stat & next_irq_en);
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_type_chooser <= ENU_CHOOSER_RST;
      notify_on_off <= ENU_NOTIFY_RST;
      irq_en <= ENU_IRQ_EN_RST;
      irq_stat <= 9'h000;
      pend <= 9'h000;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      irq <= 1'b0;
      for (int i = 0; i < ENU_NUM_EVT; i++) begin
        evt_time[i] <= ENU_TIME_RST;
      end
    end else begin
      event_type_chooser <= next_chooser;
      notify_on_off <= next_notify;
      irq_en <= next_irq_en;
      irq_stat <= next_irq_stat;
      pend <= next_pend;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      irq <= next_irq;
      evt_time <= next_evt_time;
    end
  end

  // ----------------------------------------
  // Packet sender
  // ----------------------------------------
  enu_packet u_packet (
    .pclk(pclk),
    .presetn(presetn),
    .req(send_req),
    .req_code(enu_code(send_idx)),
    .req_time(evt_time[send_idx]),
    .busy(pkt_busy),
    .pkt_valid(pkt_valid),
    .pkt_code(pkt_code),
    .pkt_time(pkt_time),
    .pkt_ready(pkt_ready)
  );

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_accept_code: assert property (@(posedge pclk) disable iff (!presetn)
    send_req && !pkt_busy && send_idx == 4'h0 |=> pkt_code == ENU_CODE_TRIG_ACC)
    else $error("accepted code bad");
  a_time_capture: assert property (@(posedge pclk) disable iff (!presetn)
    trigger_accepted_event |=> evt_time[0] == $past(evt.now))
    else $error("timestamp not captured");
  a_rej_time: assert property (@(posedge pclk) disable iff (!presetn)
    trigger_rejected_event |=> evt_time[1] == $past(evt.now))
    else $error("reject timestamp bad");
  a_off_no_pend: assert property (@(posedge pclk) disable iff (!presetn)
    (notify_on_off == 9'h000 && pend == 9'h000) |=> pend == 9'h000)
    else $error("pending while off");
  a_pend_code: assert property (@(posedge pclk) disable iff (!presetn)
    send_req && !pkt_busy |=> pkt_valid && pkt_code == enu_code($past(send_idx)))
    else $error("packet code wrong");
  a_pkt_hold: assert property (@(posedge pclk) disable iff (!presetn)
    pkt_valid && !pkt_ready |=> pkt_valid && $stable(pkt_code) && $stable(pkt_time))
    else $error("packet dropped");
  a_chooser_range: assert property (@(posedge pclk) disable iff (!presetn)
    event_type_chooser < 4'(ENU_NUM_EVT))
    else $error("chooser out of range");
  a_exp_code: assert property (@(posedge pclk) disable iff (!presetn)
    send_req && !pkt_busy && send_idx == 4'h5 |=> pkt_code == ENU_CODE_EXP_BEGIN)
    else $error("exposure code bad");
  a_notify_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_acc && paddr == ENU_OFF_NOTIFY |=> notify_on_off[$past(event_type_chooser)]
      == $past(pwdata[0]))
    else $error("notify write lost");

  // ----------------------------------------
  // Multi-step checks: milestone, pending bit, packet
  // ----------------------------------------
  // Alone on an idle link, so no lower index can jump the queue
  sequence s_exp_alone;
    evt.hit == 9'h020 && notify_on_off[5] && pend == 9'h000 && !pkt_valid;
  endsequence
  sequence s_exp_packet;
    pkt_valid && pkt_code == ENU_CODE_EXP_BEGIN;
  endsequence
  sequence s_tmr_alone;
    evt.hit == 9'h100 && notify_on_off[8] && pend == 9'h000 && !pkt_valid;
  endsequence
  sequence s_tmr_packet;
    pkt_valid && pkt_code == ENU_CODE_TMR_FINISH;
  endsequence
  sequence s_accept_armed;
    trigger_accepted_event && notify_on_off[0];
  endsequence
  a_exp_packet: assert property (@(posedge pclk) disable iff (!presetn)
    s_exp_alone |-> ##2 s_exp_packet)
    else $error("exposure packet late");
  a_tmr_packet: assert property (@(posedge pclk) disable iff (!presetn)
    s_tmr_alone |-> ##2 s_tmr_packet)
    else $error("timer packet late");
  a_accept_queue: assert property (@(posedge pclk) disable iff (!presetn)
    s_accept_armed |=> pend[0])
    else $error("accepted event not queued");
  // A type that is switched off never enters the queue
  a_off_silent: assert property (@(posedge pclk) disable iff (!presetn)
    (evt.hit & ~notify_on_off & ~pend) != 9'h000
      |=> (pend & $past(evt.hit & ~notify_on_off & ~pend)) == 9'h000)
    else $error("disabled event queued");
  a_finish_stamp: assert property (@(posedge pclk) disable iff (!presetn)
    aux_timer_zero_finish_event |=> evt_time[8] == $past(evt.now))
    else $error("timer stamp bad");
  a_sel_read: assert property (@(posedge pclk) disable iff (!presetn)
    rd_acc && paddr == ENU_OFF_SEL_TIME
      |=> prdata == $past(evt_time[event_type_chooser]))
    else $error("selected stamp bad");
  a_notify_read: assert property (@(posedge pclk) disable iff (!presetn)
    rd_acc && paddr == ENU_OFF_NOTIFY
      |=> prdata == {31'h0, $past(notify_on_off[event_type_chooser])})
    else $error("notify read bad");
  a_stat_set: assert property (@(posedge pclk) disable iff (!presetn)
    trigger_rejected_event |=> irq_stat[1])
    else $error("status lost");
  // Bus handshake shape and interrupt level
  a_pready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("ready longer than one cycle");
  a_err_ready: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready)
    else $error("error without ready");
  a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    irq == |(irq_stat & irq_en))
    else $error("interrupt level wrong");
endmodule

//--- inc/enu_pkg.sv
// Package: constants, register map and helper functions of the event notification unit
package enu_pkg;
  localparam int ENU_NUM_EVT = 9;
  localparam int ENU_TS_W = 32;
  // Event codes carried in each event packet
  localparam logic [15:0] ENU_CODE_TRIG_ACC = 16'h8020;
  localparam logic [15:0] ENU_CODE_TRIG_REJ = 16'h8021;
  localparam logic [15:0] ENU_CODE_TRIG_WAIT = 16'h8022;
  localparam logic [15:0] ENU_CODE_XFER_BEGIN = 16'h8030;
  localparam logic [15:0] ENU_CODE_XFER_DONE = 16'h8031;
  localparam logic [15:0] ENU_CODE_EXP_BEGIN = 16'h8040;
  localparam logic [15:0] ENU_CODE_EXP_FINISH = 16'h8041;
  localparam logic [15:0] ENU_CODE_TMR_BEGIN = 16'h9000;
  localparam logic [15:0] ENU_CODE_TMR_FINISH = 16'h9100;
  // Register byte offsets
  localparam logic [7:0] ENU_OFF_CHOOSER = 8'h00;
  localparam logic [7:0] ENU_OFF_NOTIFY = 8'h04;
  localparam logic [7:0] ENU_OFF_SEL_TIME = 8'h08;
  localparam logic [7:0] ENU_OFF_IRQ_STAT = 8'h0c;
  localparam logic [7:0] ENU_OFF_IRQ_CLR = 8'h10;
  localparam logic [7:0] ENU_OFF_IRQ_EN = 8'h14;
  localparam logic [7:0] ENU_OFF_NOW = 8'h18;
  localparam logic [7:0] ENU_OFF_TIME0 = 8'h20;
  localparam logic [3:0] ENU_CHOOSER_RST = 4'h0;
  localparam logic [8:0] ENU_NOTIFY_RST = 9'h000;
  localparam logic [8:0] ENU_IRQ_EN_RST = 9'h000;
  localparam logic [31:0] ENU_TIME_RST = 32'h0000_0000;

  function automatic logic [15:0] enu_code(input logic [3:0] idx);
    logic [15:0] c;
    c = ENU_CODE_TRIG_ACC;
    unique case (idx)
      4'h1: c = ENU_CODE_TRIG_REJ;
      4'h2: c = ENU_CODE_TRIG_WAIT;
      4'h3: c = ENU_CODE_XFER_BEGIN;
      4'h4: c = ENU_CODE_XFER_DONE;
      4'h5: c = ENU_CODE_EXP_BEGIN;
      4'h6: c = ENU_CODE_EXP_FINISH;
      4'h7: c = ENU_CODE_TMR_BEGIN;
      4'h8: c = ENU_CODE_TMR_FINISH;
      default: c = ENU_CODE_TRIG_ACC;
    endcase
    return c;
  endfunction

  // Lowest pending event wins
  function automatic logic [3:0] enu_first(input logic [8:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = ENU_NUM_EVT - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction
endpackage

//--- inc/enu_evt_if.sv
// Interface: detected events with their capture time
`timescale 1ns/1ns
interface enu_evt_if;
  logic [8:0] hit;
  logic [31:0] now;
  modport src (output hit, output now);
  modport dst (input hit, input now);
endinterface

//--- rtl/enu_detect.sv
// Event detection and free-running time counter
`timescale 1ns/1ns
module enu_detect
  import enu_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Pipeline milestones, one-cycle pulses
  input wire logic [8:0] milestone,
  // To the core
  enu_evt_if.src evt
);
  logic [31:0] time_cnt;
  logic [31:0] next_time_cnt;

  always_comb begin
    next_time_cnt = time_cnt + 32'h0000_0001;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      time_cnt <= ENU_TIME_RST;
    end else begin
      time_cnt <= next_time_cnt;
    end
  end

  // Combinational so the time sampled matches the detection cycle
  assign evt.hit = milestone;
  assign evt.now = time_cnt;
endmodule

//--- rtl/enu_packet.sv
// Event packet sender: holds one packet until the link takes it
`timescale 1ns/1ns
module enu_packet
  import enu_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Packet request
  input wire logic req,
  input wire logic [15:0] req_code,
  input wire logic [31:0] req_time,
  output logic busy,
  // Link side
  output logic pkt_valid,
  output logic [15:0] pkt_code,
  output logic [31:0] pkt_time,
  input wire logic pkt_ready
);
  logic next_valid;
  logic [15:0] next_code;
  logic [31:0] next_time;

  always_comb begin
    next_valid = pkt_valid;
    next_code = pkt_code;
    next_time = pkt_time;
    if (pkt_valid && pkt_ready) begin
      next_valid = 1'b0;
    end
    if (req && !pkt_valid) begin
      next_valid = 1'b1;
      next_code = req_code;
      next_time = req_time;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pkt_valid <= 1'b0;
      pkt_code <= 16'h0000;
      pkt_time <= ENU_TIME_RST;
    end else begin
      pkt_valid <= next_valid;
      pkt_code <= next_code;
      pkt_time <= next_time;
    end
  end

  assign busy = pkt_valid;
endmodule

//--- tb/enu_host_model.sv
// Host side of the event packet link: takes packets with random stalls
`timescale 1ns/1ns
module enu_host_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Packet link
  input wire logic pkt_valid,
  input wire logic [15:0] pkt_code,
  input wire logic [31:0] pkt_time,
  output logic pkt_ready,
  // Last packet taken
  output int got_n,
  output logic [15:0] got_code,
  output logic [31:0] got_time
);
  // Ready never stays high two cycles, so the bench sees every packet
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pkt_ready <= 1'b0;
      got_n <= 0;
      got_code <= 16'h0000;
      got_time <= 32'h0000_0000;
    end else begin
      pkt_ready <= !pkt_ready && ($urandom_range(0, 1) == 1);
      if (pkt_valid && pkt_ready) begin
        got_n <= got_n + 1;
        got_code <= pkt_code;
        got_time <= pkt_time;
      end
    end
  end
endmodule

//--- tb/tb_top.sv
// Self-checking bench of the event notification unit
`timescale 1ns/1ns
module tb_top;
  import enu_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, pkt_valid, pkt_ready, irq, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, pkt_time, rd, t0, got_time;
  logic [15:0] pkt_code, got_code;
  logic [8:0] ev;
  int bad_count, total_checks, got_n, g, i;

  enu_top enu_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .trigger_accepted_event(ev[0]), .trigger_rejected_event(ev[1]),
    .trigger_wait_event(ev[2]), .transfer_begin_event(ev[3]),
    .transfer_complete_event(ev[4]), .exposure_begin_event(ev[5]),
    .exposure_finish_event(ev[6]), .aux_timer_zero_begin_event(ev[7]),
    .aux_timer_zero_finish_event(ev[8]), .pkt_valid(pkt_valid), .pkt_code(pkt_code),
    .pkt_time(pkt_time), .pkt_ready(pkt_ready), .irq(irq));
  enu_host_model enu_host_model_i (.pclk(pclk), .presetn(presetn), .pkt_valid(pkt_valid),
    .pkt_code(pkt_code), .pkt_time(pkt_time), .pkt_ready(pkt_ready), .got_n(got_n),
    .got_code(got_code), .got_time(got_time));

  always #10 pclk = ~pclk;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [15:0] exp_code(input int n);
    logic [15:0] t [9] = '{16'h8020, 16'h8021, 16'h8022, 16'h8030, 16'h8031,
      16'h8040, 16'h8041, 16'h9000, 16'h9100};
    return t[n];
  endfunction

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      bad_count++;
      $display("Error %0t: got %h expected %h", $time, s, e);
    end
  endtask

  task automatic wrap_up();
    if (bad_count == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      chk(32'(n), 32'h0);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic fire(input logic [8:0] m);
    @(posedge pclk);
    ev <= m;
    @(posedge pclk);
    ev <= 9'h000;
  endtask

  task automatic wait_pkt(input int n);
    int c;
    c = 0;
    while (got_n < n && c < 200) begin
      @(posedge pclk);
      c++;
    end
    if (got_n < n) begin
      chk(32'(got_n), 32'(n));
    end
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, ev} = '0;
    void'($urandom(32'h1e35d901));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ENU_OFF_CHOOSER, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, ENU_OFF_NOTIFY, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h1c, 32'h0);
    chk(32'(er), 32'h1);
    // Past the last timestamp slot: must not fold back onto slot zero
    apb(1'b0, 8'h60, 32'h0);
    chk(32'(er), 32'h1);
    apb(1'b0, 8'h44 + 8'(4 * $urandom_range(0, 46)), 32'h0);
    chk(32'(er), 32'h1);
    apb(1'b1, ENU_OFF_CHOOSER, 32'h9);
    chk(32'(er), 32'h1);
    apb(1'b0, ENU_OFF_CHOOSER, 32'h0);
    chk(rd, 32'h0);
    fire(9'h001);
    repeat (10) @(posedge pclk);
    chk(32'(got_n), 32'h0);
    g = $urandom_range(1, 20);
    fire(9'h002);
    repeat (g) @(posedge pclk);
    fire(9'h004);
    apb(1'b0, ENU_OFF_TIME0 + 8'h04, 32'h0);
    t0 = rd;
    apb(1'b0, ENU_OFF_TIME0 + 8'h08, 32'h0);
    chk(rd - t0, 32'(g + 2));
    apb(1'b1, ENU_OFF_CHOOSER, 32'h2);
    apb(1'b0, ENU_OFF_SEL_TIME, 32'h0);
    chk(rd - t0, 32'(g + 2));
    for (int k = 0; k < 9; k++) begin
      i = (k + g) % 9;
      apb(1'b1, ENU_OFF_CHOOSER, 32'(i));
      apb(1'b1, ENU_OFF_NOTIFY, 32'h1);
      apb(1'b0, ENU_OFF_NOTIFY, 32'h0);
      chk(rd, 32'h1);
      fire(9'(1 << i));
      wait_pkt(k + 1);
      chk(32'(got_code), 32'(exp_code(i)));
      apb(1'b0, ENU_OFF_TIME0 + 8'(4 * i), 32'h0);
      chk(got_time, rd);
    end
    // All at once: lowest index leaves first
    fire(9'h1ff);
    for (int k = 0; k < 9; k++) begin
      wait_pkt(10 + k);
      chk(32'(got_code), 32'(exp_code(k)));
    end
    apb(1'b0, ENU_OFF_IRQ_STAT, 32'h0);
    chk(rd, 32'h1ff);
    chk(32'(irq), 32'h0);
    apb(1'b1, ENU_OFF_IRQ_EN, 32'h1ff);
    repeat (2) @(posedge pclk);
    chk(32'(irq), 32'h1);
    apb(1'b1, ENU_OFF_IRQ_CLR, 32'h1ff);
    apb(1'b0, ENU_OFF_IRQ_STAT, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, ENU_OFF_IRQ_EN, 32'h2);
    fire(9'h001);
    repeat (3) @(posedge pclk);
    chk(32'(irq), 32'h0);
    fire(9'h002);
    repeat (3) @(posedge pclk);
    chk(32'(irq), 32'h1);
    // Reset in mid-run brings back the defaults
    apb(1'b1, ENU_OFF_CHOOSER, 32'($urandom_range(1, 8)));
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    chk(32'(irq), 32'h0);
    apb(1'b0, ENU_OFF_CHOOSER, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, ENU_OFF_NOTIFY, 32'h0);
    chk(rd, 32'h0);
    fire(9'h1ff);
    repeat (10) @(posedge pclk);
    chk(32'(got_n), 32'h0);
    chk(32'(irq), 32'h0);
    wrap_up();
  end

  initial begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    wrap_up();
  end
endmodule
